// ---- psa_pkg.sv ----
package psa_pkg;

    // register addresses on the management port
    localparam logic [4:0]  PSA_ADDR_STATUS = 5'h01;
    localparam logic [4:0]  PSA_ADDR_ID_HI  = 5'h02;
    localparam logic [4:0]  PSA_ADDR_ID_LO  = 5'h03;
    localparam logic [4:0]  PSA_ADDR_ADV    = 5'h04;

    // status bit positions
    localparam int PSA_ST_10FD = 12;
    localparam int PSA_ST_10HD = 11;
    localparam int PSA_ST_PRE  = 6;
    localparam int PSA_ST_ANC  = 5;
    localparam int PSA_ST_RF   = 4;
    localparam int PSA_ST_ANA  = 3;
    localparam int PSA_ST_LINK = 2;
    localparam int PSA_ST_JAB  = 1;
    localparam int PSA_ST_EXT  = 0;

    // fixed capability values
    localparam logic PSA_CAP_10FD = 1'b1;
    localparam logic PSA_CAP_10HD = 1'b1;
    localparam logic PSA_CAP_PRE  = 1'b1;
    localparam logic PSA_CAP_EXT  = 1'b1;

    // identity fields, values arbitrary
    localparam logic [15:0] PSA_OUI_HI = 16'h5A3C;
    localparam logic [5:0]  PSA_OUI_LO = 6'h15;
    localparam logic [5:0]  PSA_MODEL  = 6'h2A;
    localparam logic [3:0]  PSA_REV    = 4'h3;

    // advertisement layout
    localparam logic [15:0] PSA_ADV_RESET = 16'h01E1;
    localparam logic [15:0] PSA_ADV_WMASK = 16'hA7FF;
    localparam int PSA_ADV_NP    = 15;
    localparam int PSA_ADV_RF    = 13;
    localparam int PSA_ADV_PAUSE = 10;
    localparam int PSA_ADV_SEL_H = 4;

    localparam logic [15:0] PSA_ZERO16 = 16'h0000;

    typedef struct packed {
        logic [15:0] rdata;
        logic        rvalid;
        logic [15:0] adv;
        logic        rf;
        logic        jab;
        logic        link;
        logic        strap_s1;
        logic        strap_s2;
    } psa_state_t;

endpackage

// ---- psa_regs.sv ----
`timescale 1ns/1ps
// Functional notes
// - status bits 12 and 11 report 10 Mb/s full and half duplex support.
// - status bit 6 reports that preamble-free management frames are accepted.
// - status bit 5 reads 1 only once negotiation has finished.
// - negotiation-complete reads 0 whenever negotiation is disabled.
// - remote fault latches high until fault gone and status read.
// - status bit 3 follows the strapped negotiation-capable mode pin.
// - link bit latches low until link changes and status is read.
// - jabber bit latches high until jabber gone and status read.
// - status bit 0 always reads 1.
// - identifier high register holds OUI bits 3 to 18.
// - identifier low register bits 15:10 hold OUI bits 19 to 24.
// - identifier low register holds model in 9:4, revision in 3:0.
// - advertisement bits 4:0 are the writable selector field.
// - advertisement bits 9 to 5 are writable ability bits.
// - advertisement bit 10 writable, advertises pause support.
// - bit 13 remote fault, bit 15 next page; 14, 12, 11 reserved.
// - advertisement resets to 0x01E1.
// - control bit 12 enables negotiation and gates the complete flag.
module psa_regs
    import psa_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_ce,
    input  wire logic [4:0]  i_addr,
    input  wire logic        i_rd,
    input  wire logic        i_wr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_an_enable,
    input  wire logic        i_an_done,
    input  wire logic        i_remote_fault,
    input  wire logic        i_link_up,
    input  wire logic        i_jabber,
    input  wire logic        i_strap_an_able,
    output logic      [15:0] o_rdata,
    output logic             o_rvalid,
    output logic      [15:0] o_adv
);

    psa_state_t s_r;
    psa_state_t s_nxt;
    logic       rd_stat;
    logic       wr_adv;
    logic [15:0] status_w;

    // latch that holds high until event gone and register read
    function automatic logic sticky_hi(input logic ev,
                                       input logic cur,
                                       input logic rd);
        return ev | (cur & ~rd);
    endfunction

    assign rd_stat = i_ce & i_rd & (i_addr == PSA_ADDR_STATUS);
    assign wr_adv  = i_ce & i_wr & (i_addr == PSA_ADDR_ADV);

    always_comb begin
        status_w = PSA_ZERO16;
        status_w[PSA_ST_10FD] = PSA_CAP_10FD;
        status_w[PSA_ST_10HD] = PSA_CAP_10HD;
        status_w[PSA_ST_PRE]  = PSA_CAP_PRE;
        status_w[PSA_ST_ANC]  = i_an_enable & i_an_done;
        status_w[PSA_ST_RF]   = s_r.rf;
        status_w[PSA_ST_ANA]  = s_r.strap_s2;
        status_w[PSA_ST_LINK] = s_r.link;
        status_w[PSA_ST_JAB]  = s_r.jab;
        status_w[PSA_ST_EXT]  = PSA_CAP_EXT;
    end

    always_comb begin
        s_nxt = s_r;
        if (i_ce) begin
            s_nxt.strap_s1 = i_strap_an_able;
            s_nxt.strap_s2 = s_r.strap_s1;
            s_nxt.rf = sticky_hi(i_remote_fault, s_r.rf, rd_stat);
            s_nxt.jab = sticky_hi(i_jabber, s_r.jab, rd_stat);
            s_nxt.link = i_link_up & (s_r.link | rd_stat);
            if (wr_adv) begin
                s_nxt.adv = i_wdata & PSA_ADV_WMASK;
            end
            s_nxt.rvalid = i_rd;
            if (i_rd) begin
                unique case (i_addr)
                    PSA_ADDR_STATUS: s_nxt.rdata = status_w;
                    PSA_ADDR_ID_HI: s_nxt.rdata = PSA_OUI_HI;
                    PSA_ADDR_ID_LO: s_nxt.rdata = {PSA_OUI_LO, PSA_MODEL,
                                                   PSA_REV};
                    PSA_ADDR_ADV: s_nxt.rdata = s_r.adv;
                    default: s_nxt.rdata = PSA_ZERO16;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s_r.rdata    <= PSA_ZERO16;
            s_r.rvalid   <= 1'b0;
            s_r.adv      <= PSA_ADV_RESET;
            s_r.rf       <= 1'b0;
            s_r.jab      <= 1'b0;
            s_r.link     <= 1'b0;
            s_r.strap_s1 <= 1'b0;
            s_r.strap_s2 <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_rdata  = s_r.rdata;
    assign o_rvalid = s_r.rvalid;
    assign o_adv    = s_r.adv;

    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    property p_fixed_caps;
        rd_stat |=> (o_rdata[PSA_ST_10FD] && o_rdata[PSA_ST_10HD]
                     && o_rdata[PSA_ST_PRE] == PSA_CAP_PRE
                     && o_rdata[PSA_ST_EXT] && o_rvalid);
    endproperty
    a_fixed_caps: assert property (p_fixed_caps)
        else $error("fixed status capability bits wrong");

    property p_anc_gate;
        (rd_stat && !i_an_enable) |=> !o_rdata[PSA_ST_ANC];
    endproperty
    a_anc_gate: assert property (p_anc_gate)
        else $error("complete flag set while negotiation disabled");

    property p_anc_done;
        rd_stat |=> o_rdata[PSA_ST_ANC] == $past(i_an_enable & i_an_done);
    endproperty
    a_anc_done: assert property (p_anc_done)
        else $error("complete flag does not follow negotiation");

    property p_rf_set;
        (i_ce && i_remote_fault) |=> (s_r.rf
            and (rd_stat |=> o_rdata[PSA_ST_RF]));
    endproperty
    a_rf_set: assert property (p_rf_set)
        else $error("remote fault not latched");

    property p_rf_hold;
        (s_r.rf && !rd_stat) |=> s_r.rf;
    endproperty
    a_rf_hold: assert property (p_rf_hold)
        else $error("remote fault cleared without read");

    property p_strap;
        ($past(i_ce, 1) && $past(i_ce, 2)
            && !$past(i_reset, 1) && !$past(i_reset, 2))
            |-> s_r.strap_s2 == $past(i_strap_an_able, 2);
    endproperty
    a_strap: assert property (p_strap)
        else $error("ability bit does not follow strap");

    property p_link_low;
        (i_ce && !i_link_up) |=> (!s_r.link
            and (!rd_stat |=> !s_r.link));
    endproperty
    a_link_low: assert property (p_link_low)
        else $error("link bit not latched low");

    property p_link_read;
        (rd_stat && i_link_up) |=> s_r.link;
    endproperty
    a_link_read: assert property (p_link_read)
        else $error("link bit not restored on read");

    property p_jab;
        (i_ce && i_jabber) |=> (s_r.jab
            and (!rd_stat |=> s_r.jab));
    endproperty
    a_jab: assert property (p_jab)
        else $error("jabber not latched");

    property p_id_hi;
        (i_ce && i_rd && i_addr == PSA_ADDR_ID_HI)
            |=> o_rdata == PSA_OUI_HI;
    endproperty
    a_id_hi: assert property (p_id_hi)
        else $error("identifier high value wrong");

    property p_id_lo;
        (i_ce && i_rd && i_addr == PSA_ADDR_ID_LO)
            |=> o_rdata == {PSA_OUI_LO, PSA_MODEL, PSA_REV};
    endproperty
    a_id_lo: assert property (p_id_lo)
        else $error("identifier low value wrong");

    property p_adv_wr;
        wr_adv |=> ((o_adv == ($past(i_wdata) & PSA_ADV_WMASK))
            and (!wr_adv |=> $stable(o_adv)));
    endproperty
    a_adv_wr: assert property (p_adv_wr)
        else $error("advertisement write wrong");

    property p_ro_wr;
        (i_wr && i_addr != PSA_ADDR_ADV) |=> $stable(o_adv);
    endproperty
    a_ro_wr: assert property (p_ro_wr)
        else $error("read-only write changed state");

    property p_adv_reset;
        @(posedge i_clk) disable iff (1'b0)
            i_reset |=> (o_adv == PSA_ADV_RESET && !o_rvalid);
    endproperty
    a_adv_reset: assert property (p_adv_reset)
        else $error("advertisement reset value wrong");

    property p_rvalid;
        i_ce |=> o_rvalid == $past(i_rd);
    endproperty
    a_rvalid: assert property (p_rvalid)
        else $error("read valid does not follow request");

    property p_ce_freeze;
        !i_ce |=> $stable(s_r);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze)
        else $error("state changed while clock enable low");

    property p_stat_word;
        rd_stat |=> o_rdata == {3'h0, PSA_CAP_10FD, PSA_CAP_10HD, 4'h0,
                                PSA_CAP_PRE,
                                $past(i_an_enable & i_an_done),
                                $past(s_r.rf), $past(s_r.strap_s2),
                                $past(s_r.link), $past(s_r.jab),
                                PSA_CAP_EXT};
    endproperty
    a_stat_word: assert property (p_stat_word)
        else $error("status word wrong");

    property p_adv_rsvd;
        (o_adv & ~PSA_ADV_WMASK) == PSA_ZERO16;
    endproperty
    a_adv_rsvd: assert property (p_adv_rsvd)
        else $error("reserved advertisement bit set");

    property p_rf_clear;
        (rd_stat && !i_remote_fault) |=> !s_r.rf;
    endproperty
    a_rf_clear: assert property (p_rf_clear)
        else $error("remote fault not cleared by read");

    property p_jab_clear;
        (rd_stat && !i_jabber) |=> !s_r.jab;
    endproperty
    a_jab_clear: assert property (p_jab_clear)
        else $error("jabber not cleared by read");

    property p_link_stuck;
        (!s_r.link && !rd_stat) |=> !s_r.link;
    endproperty
    a_link_stuck: assert property (p_link_stuck)
        else $error("link bit rose without read");

    property p_adv_read;
        (i_ce && i_rd && i_addr == PSA_ADDR_ADV)
            |=> o_rdata == $past(o_adv);
    endproperty
    a_adv_read: assert property (p_adv_read)
        else $error("advertisement read value wrong");

    property p_unmapped;
        (i_ce && i_rd && i_addr > PSA_ADDR_ADV)
            |=> o_rdata == PSA_ZERO16;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_rd_hold;
        (i_ce && !i_rd) |=> $stable(o_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data changed without read");

    property p_ro_latch;
        (i_wr && !i_rd && i_link_up && !i_remote_fault && !i_jabber)
            |=> ($stable(s_r.rf) && $stable(s_r.jab)
                 && $stable(s_r.link));
    endproperty
    a_ro_latch: assert property (p_ro_latch)
        else $error("write changed a latched indication");

    property p_cv_rf_clear;
        s_r.rf ##1 rd_stat ##1 !s_r.rf;
    endproperty
    c_rf_clear: cover property (p_cv_rf_clear);

    property p_cv_link_drop;
        s_r.link ##1 !s_r.link ##[1:8] rd_stat ##1 s_r.link;
    endproperty
    c_link_drop: cover property (p_cv_link_drop);

    property p_cv_adv;
        wr_adv ##[1:4] (i_ce && i_rd && i_addr == PSA_ADDR_ADV);
    endproperty
    c_adv: cover property (p_cv_adv);

    property p_cv_jab_clear;
        s_r.jab ##1 rd_stat ##1 !s_r.jab;
    endproperty
    c_jab_clear: cover property (p_cv_jab_clear);

    property p_cv_freeze;
        !i_ce ##1 !i_ce ##1 i_ce;
    endproperty
    c_freeze: cover property (p_cv_freeze);

endmodule

// ---- psa_host.sv ----
`timescale 1ns/1ps
// host side of the management access path
module psa_host (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_rdata,
    input  wire logic        i_rvalid,
    output logic             o_ce,
    output logic      [4:0]  o_addr,
    output logic             o_rd,
    output logic             o_wr,
    output logic      [15:0] o_wdata
);
    initial begin
        o_ce = 1'b1;
        o_addr = 5'h00;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_wdata = 16'h0000;
    end

    task automatic rd(input logic [4:0] a, output logic [15:0] d,
                      output logic v);
        @(posedge i_clk);
        #1 o_addr = a;
        o_rd = 1'b1;
        @(posedge i_clk);
        #1 o_rd = 1'b0;
        d = i_rdata;
        v = i_rvalid;
        o_addr = ~a;
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_clk);
        #1 o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(posedge i_clk);
        #1 o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask

    // clock enable for freeze tests
    task automatic set_ce(input logic e);
        @(posedge i_clk);
        #1 o_ce = e;
    endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top import psa_pkg::*;;
    logic        i_clk;
    logic        i_reset;
    logic        an_en;
    logic        an_done;
    logic        rfault;
    logic        link;
    logic        jab;
    logic        strap;
    logic        ce;
    logic        rd;
    logic        wr;
    logic        v;
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        rvalid;
    logic [15:0] adv;
    logic [15:0] d;
    logic [15:0] w;
    logic [31:0] seed;
    int          mismatches;
    int          num_checks;

    psa_regs psa_regs_i (.i_clk(i_clk), .i_reset(i_reset), .i_ce(ce),
        .i_addr(addr), .i_rd(rd), .i_wr(wr), .i_wdata(wdata),
        .i_an_enable(an_en), .i_an_done(an_done), .i_remote_fault(rfault),
        .i_link_up(link), .i_jabber(jab), .i_strap_an_able(strap),
        .o_rdata(rdata), .o_rvalid(rvalid), .o_adv(adv));
    psa_host psa_host_i (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid),
        .o_ce(ce), .o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wdata));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [15:0] stat(logic c, logic f, logic a,
                                         logic l, logic j);
        return {3'h0, PSA_CAP_10FD, PSA_CAP_10HD, 4'h0, PSA_CAP_PRE,
                c, f, a, l, j, PSA_CAP_EXT};
    endfunction

    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            mismatches++;
        end
    endtask

    task automatic rdc(logic [4:0] a, logic [15:0] e);
        psa_host_i.rd(a, d, v);
        chk("rvalid", {15'h0000, v}, 16'h0001);
        chk("rdata", d, e);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    initial begin
        #20000;
        mismatches++;
        conclude();
    end

    initial begin
        {an_done, rfault, link, jab} = 4'h0;
        {i_reset, an_en, strap} = 3'b111;
        seed = 32'h4afe_3dda;
        repeat (3) @(posedge i_clk);
        #1 i_reset = 1'b0;
        chk("adv", adv, 16'h01E1);
        link = 1'b1;
        an_done = 1'b1;
        repeat (2) @(posedge i_clk);
        rdc(PSA_ADDR_STATUS, stat(1, 0, 1, 0, 0));
        rdc(PSA_ADDR_STATUS, stat(1, 0, 1, 1, 0));
        an_en = 1'b0;
        rdc(PSA_ADDR_STATUS, stat(0, 0, 1, 1, 0));
        an_en = 1'b1;
        @(posedge i_clk);
        #1 {rfault, jab, link} = 3'b110;
        @(posedge i_clk);
        #1 {rfault, jab} = 2'b00;
        rdc(PSA_ADDR_STATUS, stat(1, 1, 1, 0, 1));
        link = 1'b1;
        rdc(PSA_ADDR_STATUS, stat(1, 0, 1, 0, 0));
        rfault = 1'b1;
        rdc(PSA_ADDR_STATUS, stat(1, 1, 1, 1, 0));
        rfault = 1'b0;
        rdc(PSA_ADDR_STATUS, stat(1, 1, 1, 1, 0));
        strap = 1'b0;
        repeat (3) @(posedge i_clk);
        rdc(PSA_ADDR_STATUS, stat(1, 0, 0, 1, 0));
        for (int i = 0; i < 2; i++) begin
            rdc(PSA_ADDR_ID_HI, PSA_OUI_HI);
            rdc(PSA_ADDR_ID_LO, {PSA_OUI_LO, PSA_MODEL, PSA_REV});
            psa_host_i.wr(PSA_ADDR_ID_HI, 16'hFFFF);
            psa_host_i.wr(PSA_ADDR_ID_LO, 16'h0000);
            psa_host_i.wr(PSA_ADDR_STATUS, 16'h0000);
        end
        rdc(PSA_ADDR_STATUS, stat(1, 0, 0, 1, 0));
        for (int i = 0; i < 12; i++) begin
            w = 16'(xs());
            if (i == 0) w = 16'hFFFF;
            if (i == 1) w = 16'h0000;
            psa_host_i.wr(PSA_ADDR_ADV, w);
            chk("adv", adv, w & 16'hA7FF);
            rdc(PSA_ADDR_ADV, w & 16'hA7FF);
            rdc(5'(xs() % 27 + 5), 16'h0000);
        end
        psa_host_i.set_ce(1'b0);
        jab = 1'b1;
        psa_host_i.wr(PSA_ADDR_ADV, 16'h0000);
        jab = 1'b0;
        psa_host_i.set_ce(1'b1);
        chk("adv", adv, w & 16'hA7FF);
        rdc(PSA_ADDR_STATUS, stat(1, 0, 0, 1, 0));
        @(posedge i_clk);
        #1 i_reset = 1'b1;
        @(posedge i_clk);
        #1 i_reset = 1'b0;
        chk("adv", adv, 16'h01E1);
        rdc(PSA_ADDR_STATUS, stat(1, 0, 0, 0, 0));
        conclude();
    end
endmodule
